// File: tb/tocp_load.sv
// pwm load on a timer pin, measuring period and high time
`timescale 1ns/1ps
`default_nettype none
module tocp_load (
	input  wire logic        clk_i,
	input  wire logic        pin_i,
	input  wire logic        oe_n_i,
	output logic             line_o,
	output logic      [15:0] per_o,
	output logic      [15:0] hi_o
);
	logic        prev = 1'b0;
	logic [15:0] per_c = 16'h0000;
	logic [15:0] hi_c = 16'h0000;
	// a released pin is pulled low by the load
	assign line_o = oe_n_i ? 1'b0 : pin_i;
	// both counts restart at every rising edge of the line
	always @(posedge clk_i) begin
		prev <= line_o;
		if (line_o && !prev) begin
			per_o <= per_c;
			hi_o <= hi_c;
			per_c <= 16'h0001;
			hi_c <= 16'h0001;
		end else begin
			per_c <= per_c + 16'h0001;
			hi_c <= hi_c + {15'h0000, line_o};
		end
	end
endmodule
`default_nettype wire

// File: tb/tocp_timer_props.sv
// concurrent checks on the timer bus and pin ports
`timescale 1ns/1ps
`default_nettype none
`include "tocp_cfg.svh"
module tocp_timer_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic        ack_o,
	input wire logic        chan0_pin_o,
	input wire logic        chan0_pin_oe_n_o,
	input wire logic        chan1_pin_oe_n_o
);
	logic [7:0] c0;
	logic [7:0] c1;
	logic       halt;
	// shadow of the control bytes, taken at the write's ack edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			c0 <= 8'h00;
			c1 <= 8'h00;
			halt <= 1'b1;
		end else if (cyc_i && stb_i && we_i && ack_o && sel_i[0]) begin
			if (adr_i == `TOCP_ADDR_CSC0)
				c0 <= dat_i[7:0];
			if (adr_i == `TOCP_ADDR_CSC1)
				c1 <= dat_i[7:0];
			if (adr_i == `TOCP_ADDR_TSC)
				halt <= dat_i[`TOCP_TSC_HALT];
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_take; cyc_i && stb_i && !ack_o; endsequence
	sequence s_idle0; (c0[5:4] == 2'h0) [*3]; endsequence
	sequence s_link; c0[5] [*3]; endsequence
	sequence s_drv0; (c0[5:4] != 2'h0 && c0[3:2] != 2'h0) [*3]; endsequence
	sequence s_drv1; (c1[4] && c1[3:2] != 2'h0 && !c0[5]) [*3]; endsequence
	sequence s_max; (c0[5:4] == 2'h1 && c0[3:0] == 4'h9) [*6]; endsequence
	sequence s_halt; (halt && $stable(c0)) [*4]; endsequence
	ack_lat_a: assert property (s_take |=> ack_o)
		else $error("no ack one cycle after request");
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("ack held longer than one cycle");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("ack without request");
	idle_quiet_a: assert property (!cyc_i |=> !ack_o)
		else $error("ack while bus idle");
	pin_release_a: assert property (s_idle0 |-> chan0_pin_oe_n_o)
		else $error("channel 0 pin driven outside output modes");
	link_free_a: assert property (s_link |-> chan1_pin_oe_n_o)
		else $error("channel 1 pin driven while linked");
	pin_drive_a: assert property (s_drv0 |-> !chan0_pin_oe_n_o)
		else $error("channel 0 pin not driven in output mode");
	chan1_drive_a: assert property (s_drv1 |-> !chan1_pin_oe_n_o)
		else $error("channel 1 pin not driven in output mode");
	max_duty_a: assert property (s_max |-> chan0_pin_o)
		else $error("full duty not held high");
	halt_hold_a: assert property (s_halt |-> $stable(chan0_pin_o))
		else $error("pin moved while counter halted");
endmodule
bind tocp_timer tocp_timer_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i,
	.we_i, .adr_i, .sel_i, .dat_i, .ack_o, .chan0_pin_o, .chan0_pin_oe_n_o,
	.chan1_pin_oe_n_o);
`default_nettype wire

// File: tb/tocp_timer_tb_top.sv
// self-checking bench for the timer output compare block
`timescale 1ns/1ps
`default_nettype none
`include "tocp_cfg.svh"
module tocp_timer_tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        irq_o;
	logic        chan0_pin_o;
	logic        chan0_pin_oe_n_o;
	logic        chan1_pin_o;
	logic        chan1_pin_oe_n_o;
	logic        line0;
	logic [15:0] per;
	logic [15:0] hi;
	logic [31:0] rd;
	int          mismatches = 0;
	int          n_compared = 0;
	always #20 clk_i = ~clk_i;
	tocp_timer dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .dat_o, .ack_o, .irq_o, .chan0_pin_o, .chan0_pin_oe_n_o,
		.chan1_pin_o, .chan1_pin_oe_n_o);
	tocp_load load0 (.clk_i, .pin_i(chan0_pin_o), .oe_n_i(chan0_pin_oe_n_o),
		.line_o(line0), .per_o(per), .hi_o(hi));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [15:0] d);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h3;
		dat_i <= {16'h0000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		rd = dat_o;
		if (ack_o !== 1'b1) begin
			mismatches++;
			close_out;
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// long enough for two full 256-cycle periods after a change
	task automatic settle;
		repeat (700) @(posedge clk_i);
	endtask
	task automatic highs(input logic [31:0] exp);
		logic [31:0] n;
		n = 32'h0;
		repeat (512) begin
			@(posedge clk_i);
			n = n + {31'h0, line0};
		end
		check(n, exp);
	endtask
	task automatic t_regs;
		bus(1'b0, `TOCP_ADDR_TSC, 16'h0000);
		check(rd, 32'h0000_0020);
		bus(1'b1, 8'h40, 16'h00FF);
		bus(1'b0, 8'h40, 16'h0000);
		check(rd, 32'h0);
		check({31'h0, chan0_pin_oe_n_o}, 32'h1);
		bus(1'b1, `TOCP_ADDR_CSC1, 16'h0018);
		repeat (4) @(posedge clk_i);
		check({31'h0, chan1_pin_oe_n_o}, 32'h0);
	endtask
	task automatic t_pwm(input logic [7:0] ctl, input logic [15:0] cmp,
			input logic [15:0] exp_hi);
		bus(1'b1, `TOCP_ADDR_TSC, 16'h0030);
		bus(1'b1, `TOCP_ADDR_MOD, 16'h00FF);
		bus(1'b1, `TOCP_ADDR_CMP0, cmp);
		bus(1'b1, `TOCP_ADDR_CSC0, {8'h00, ctl});
		bus(1'b1, `TOCP_ADDR_TSC, 16'h0000);
		settle;
		check({16'h0, per}, 32'h0000_0100);
		check({16'h0, hi}, {16'h0, exp_hi});
		check({31'h0, irq_o}, {31'h0, ctl[6]});
		bus(1'b0, `TOCP_ADDR_CSC0, 16'h0000);
		check({31'h0, rd[7]}, 32'h1);
		bus(1'b0, `TOCP_ADDR_TSC, 16'h0000);
		check({31'h0, rd[7]}, 32'h1);
	endtask
	task automatic t_duty;
		bus(1'b1, `TOCP_ADDR_CSC0, 16'h0018);
		settle;
		highs(32'h0);
		bus(1'b1, `TOCP_ADDR_CSC0, 16'h0019);
		bus(1'b1, `TOCP_ADDR_CSC1, 16'h0019);
		settle;
		highs(32'h0000_0200);
		check({31'h0, chan1_pin_o}, 32'h1);
	endtask
	task automatic t_link;
		bus(1'b1, `TOCP_ADDR_CMP0, 16'h0040);
		bus(1'b1, `TOCP_ADDR_CSC0, 16'h003A);
		settle;
		check({16'h0, hi}, 32'h0000_0040);
		check({31'h0, chan1_pin_oe_n_o}, 32'h1);
		bus(1'b1, `TOCP_ADDR_CMP1, 16'h00C0);
		settle;
		check({16'h0, hi}, 32'h0000_00C0);
		bus(1'b0, `TOCP_ADDR_PIN, 16'h0000);
		check({31'h0, rd[2]}, 32'h1);
		bus(1'b1, `TOCP_ADDR_CMP0, 16'h0020);
		settle;
		check({16'h0, hi}, 32'h0000_0020);
		// divide by two: period and width double in bus clocks
		bus(1'b1, `TOCP_ADDR_TSC, 16'h0001);
		settle;
		settle;
		check({16'h0, per}, 32'h0000_0200);
		check({16'h0, hi}, 32'h0000_0040);
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs;
		t_pwm(8'h5A, 16'h0080, 16'h0080);
		t_pwm(8'h1E, 16'h0040, 16'h00C0);
		t_duty;
		t_link;
		close_out;
	end
endmodule
`default_nettype wire

// File: verilog/tocp_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef TOCP_CFG_SVH
`define TOCP_CFG_SVH
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define TOCP_ADDR_TSC    8'h00
`define TOCP_ADDR_CNT    8'h04
`define TOCP_ADDR_MOD    8'h08
`define TOCP_ADDR_CSC0   8'h0C
`define TOCP_ADDR_CMP0   8'h10
`define TOCP_ADDR_CSC1   8'h14
`define TOCP_ADDR_CMP1   8'h18
`define TOCP_ADDR_PIN    8'h1C
// ----------------------------------------------------------------
// timer status and control fields
// ----------------------------------------------------------------
`define TOCP_TSC_OVF     7
`define TOCP_TSC_OVIE    6
`define TOCP_TSC_HALT    5
`define TOCP_TSC_RST     4
`define TOCP_TSC_PS_LO   0
`define TOCP_TSC_RESET   8'h20
// ----------------------------------------------------------------
// channel status and control fields
// ----------------------------------------------------------------
`define TOCP_CSC_FLAG    7
`define TOCP_CSC_IE      6
`define TOCP_CSC_MSB     5
`define TOCP_CSC_MSA     4
`define TOCP_CSC_ELSB    3
`define TOCP_CSC_ELSA    2
`define TOCP_CSC_TOV     1
`define TOCP_CSC_MAX     0
`define TOCP_CSC_RESET   8'h00
`define TOCP_MOD_RESET   16'hFFFF
`define TOCP_PS_MAX      3'h6
`endif

// File: verilog/tocp_pkg.sv
// types shared by the timer output compare block
package tocp_pkg;
	typedef enum logic [1:0] {
		TOCP_ACT_NONE   = 2'h0,
		TOCP_ACT_TOGGLE = 2'h1,
		TOCP_ACT_CLEAR  = 2'h2,
		TOCP_ACT_SET    = 2'h3
	} tocp_action_t;
	typedef enum logic [1:0] {
		TOCP_BUS_IDLE = 2'h1,
		TOCP_BUS_ACK  = 2'h2
	} tocp_bus_state_t;
endpackage

// File: verilog/tocp_timer.sv
// two-channel 16-bit timer with output compare and pwm, wishbone slave
//
// Function
// - unbuffered mode compares counter to channel value written directly.
// - value written below counter yields no match until next period.
// - channel flag at pulse-ending compare; overflow flag at period end.
// - channel 0 link bit joins channels; output only on channel 0 pin.
// - after linking, channel 0 compare value controls output first.
// - channel 1 write hands over at overflow; last written pair wins.
// - linked mode uses channel 0 control; channel 1 pin released.
// - toggle-on-overflow toggles pin when counter rolls over from modulo to zero.
// - pwm period is modulo plus one prescaled ticks.
// - compare value sets pulse width from overflow to match.
// - mode field 0:1 unbuffered, 1:0 buffered.
// - edge/level 1:0 clears pin on compare, 1:1 sets it.
// - channel 0 link bit wins over its other mode bit.
// - toggle-on-overflow clear with max duty bit clear stops toggles, giving zero duty.
// - max duty bit with toggle cleared gives constant active level.
// - compare match sets, clears or toggles pin per action.
// - channel flag set on each compare, interrupt when enabled.
// - halt bit stops counting, set at reset; reset bit clears counter.
// - overflow flag set on rollover after modulo match.
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tocp_cfg.svh"
module tocp_timer
	import tocp_pkg::*;
#(
	parameter int CW = 16
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             irq_o,
	output logic             chan0_pin_o,
	output logic             chan0_pin_oe_n_o,
	output logic             chan1_pin_o,
	output logic             chan1_pin_oe_n_o
);
// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
	logic [CW-1:0]   count;
	logic [CW-1:0]   modulo;
	logic [6:0]      presc;
	logic [2:0]      ps_sel;
	logic            counter_halt;
	logic            overflow_flag;
	logic            ovf_ie;
	logic            ovf_seen;
	logic [7:0]      csc [2];
	logic [CW-1:0]   cmp [2];
	logic [1:0]      chan_seen;
	logic [1:0]      level;
	logic            link_active_ch1;
	logic            link_pending_ch1;
	logic            link_on_d;
	tocp_bus_state_t bus_state;
// ----------------------------------------------------------------
// bus decode
// ----------------------------------------------------------------
	logic req;
	logic wr;
	logic rd;
	logic lane0;
	logic lane1;
	assign req   = cyc_i & stb_i & (bus_state == TOCP_BUS_IDLE);
	assign wr    = req & we_i;
	assign rd    = req & ~we_i;
	assign lane0 = sel_i[0];
	assign lane1 = sel_i[1];
// ----------------------------------------------------------------
// prescaler tick and overflow
// ----------------------------------------------------------------
	logic tick;
	logic at_mod;
	logic ovf_ev;
	logic cnt_rst;
	logic link_on;
	logic [CW-1:0] next_count;
	assign cnt_rst = wr & lane0 & (adr_i == `TOCP_ADDR_TSC)
		& dat_i[`TOCP_TSC_RST];
	// prescale 7 has no clock source here, so the counter stands still
	always_comb begin
		if (ps_sel == 3'h0) begin
			tick = 1'b1;
		end else if (ps_sel > `TOCP_PS_MAX) begin
			tick = 1'b0;
		end else begin
			tick = (presc & ((7'h01 << ps_sel) - 7'h01)) == 7'h00;
		end
	end
	assign at_mod = (count == modulo);
	assign ovf_ev = tick & ~counter_halt & at_mod & ~cnt_rst;
	assign next_count = at_mod ? '0 : count + 1'b1;
	// link bit wins over the other mode bit of channel 0
	assign link_on = csc[0][`TOCP_CSC_MSB];
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count <= '0;
			presc <= 7'h00;
		end else if (cnt_rst) begin
			count <= '0;
			presc <= 7'h00;
		end else if (!counter_halt) begin
			presc <= presc + 7'h01;
			if (tick) begin
				count <= next_count;
			end
		end
	end
// ----------------------------------------------------------------
// per-channel compare and pin logic
// ----------------------------------------------------------------
	logic [1:0] match;
	logic [1:0] drive;
	logic [1:0] ctl_en;
	logic [1:0] ch_ie;
	logic [CW-1:0] active_cmp0;
	assign active_cmp0 = (link_on && link_active_ch1) ? cmp[1] : cmp[0];
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic [7:0] ctl;
			logic [CW-1:0] cv;
			tocp_action_t act;
			// channel 0 control governs the linked pair
			assign ctl = (g == 0) ? csc[0] : csc[1];
			assign cv  = (g == 0) ? active_cmp0 : cmp[1];
			assign act = tocp_action_t'(ctl[3:2]);
			assign ctl_en[g] = (g == 0)
				? (ctl[`TOCP_CSC_MSB] | ctl[`TOCP_CSC_MSA])
				: (ctl[`TOCP_CSC_MSA] & ~link_on);
			assign drive[g] = ctl_en[g] & (act != TOCP_ACT_NONE);
			// exact equality: a value already passed gives no match.
			// the match fires on the tick that loads the compare value,
			// as the overflow toggle fires on the tick that loads zero,
			// so the pulse spans exactly the compare value in ticks;
			// comparing the present count would add one tick
			assign match[g] = ctl_en[g] & tick & ~counter_halt
				& ~cnt_rst & (next_count == cv);
			assign ch_ie[g] = ctl[`TOCP_CSC_IE];
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					level[g] <= 1'b0;
				end else if (!drive[g]) begin
					level[g] <= 1'b0;
				end else if (ctl[`TOCP_CSC_MAX] && !ctl[`TOCP_CSC_TOV])
				begin
					level[g] <= ~act[0];
				end else begin
					logic nl;
					nl = level[g];
					if (ovf_ev && ctl[`TOCP_CSC_TOV]) begin
						nl = ~nl;
					end
					if (match[g]) begin
						case (act)
							TOCP_ACT_CLEAR:  nl = 1'b0;
							TOCP_ACT_SET:    nl = 1'b1;
							TOCP_ACT_TOGGLE: nl = ~level[g];
							default:         nl = nl;
						endcase
					end
					level[g] <= nl;
				end
			end
		end
	endgenerate
// ----------------------------------------------------------------
// buffered channel hand-over
// ----------------------------------------------------------------
	logic wr_cmp0;
	logic wr_cmp1;
	assign wr_cmp0 = wr & (lane0 | lane1) & (adr_i == `TOCP_ADDR_CMP0);
	assign wr_cmp1 = wr & (lane0 | lane1) & (adr_i == `TOCP_ADDR_CMP1);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_on_d        <= 1'b0;
			link_active_ch1  <= 1'b0;
			link_pending_ch1 <= 1'b0;
		end else begin
			link_on_d <= link_on;
			if (!link_on || !link_on_d) begin
				link_active_ch1  <= 1'b0;
				link_pending_ch1 <= 1'b0;
			end else begin
				if (wr_cmp1) begin
					link_pending_ch1 <= 1'b1;
				end else if (wr_cmp0) begin
					link_pending_ch1 <= 1'b0;
				end
				if (ovf_ev) begin
					link_active_ch1 <= wr_cmp1 | (link_pending_ch1 & ~wr_cmp0);
				end
			end
		end
	end
// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
	// flags clear by writing 0 after a read saw them set; a new event wins
	// a read that finds the flag set arms the clear; the armed state is
	// dropped once the clear has been done
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			counter_halt  <= 1'b1;
			ovf_ie        <= 1'b0;
			ps_sel        <= 3'h0;
			overflow_flag <= 1'b0;
			ovf_seen      <= 1'b0;
			modulo        <= `TOCP_MOD_RESET;
		end else begin
			if (rd && adr_i == `TOCP_ADDR_TSC) begin
				ovf_seen <= overflow_flag;
			end
			if (ovf_ev) begin
				overflow_flag <= 1'b1;
			end else if (wr && lane0 && adr_i == `TOCP_ADDR_TSC
				&& !dat_i[`TOCP_TSC_OVF] && ovf_seen) begin
				overflow_flag <= 1'b0;
				ovf_seen      <= 1'b0;
			end
			if (wr && lane0 && adr_i == `TOCP_ADDR_TSC) begin
				ovf_ie       <= dat_i[`TOCP_TSC_OVIE];
				counter_halt <= dat_i[`TOCP_TSC_HALT];
				ps_sel       <= dat_i[2:0];
			end
			if (wr && adr_i == `TOCP_ADDR_MOD) begin
				if (lane0) modulo[7:0]  <= dat_i[7:0];
				if (lane1) modulo[15:8] <= dat_i[15:8];
			end
		end
	end
	generate
		for (g = 0; g < 2; g++) begin : g_reg
			localparam logic [7:0] CSC_A = (g == 0) ? `TOCP_ADDR_CSC0
				: `TOCP_ADDR_CSC1;
			localparam logic [7:0] CMP_A = (g == 0) ? `TOCP_ADDR_CMP0
				: `TOCP_ADDR_CMP1;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					csc[g]       <= `TOCP_CSC_RESET;
					chan_seen[g] <= 1'b0;
					cmp[g]       <= '0;
				end else begin
					if (rd && adr_i == CSC_A) begin
						chan_seen[g] <= csc[g][`TOCP_CSC_FLAG];
					end
					if (wr && lane0 && adr_i == CSC_A) begin
						csc[g][6:0] <= (g == 1) ? {dat_i[6], 1'b0, dat_i[4:0]}
							: dat_i[6:0];
					end
					if (match[g]) begin
						csc[g][`TOCP_CSC_FLAG] <= 1'b1;
					end else if (wr && lane0 && adr_i == CSC_A
						&& !dat_i[`TOCP_CSC_FLAG] && chan_seen[g]) begin
						csc[g][`TOCP_CSC_FLAG] <= 1'b0;
						chan_seen[g]           <= 1'b0;
					end
					if (wr && adr_i == CMP_A) begin
						if (lane0) cmp[g][7:0]  <= dat_i[7:0];
						if (lane1) cmp[g][15:8] <= dat_i[15:8];
					end
				end
			end
		end
	endgenerate
// ----------------------------------------------------------------
// read mux, ack and outputs
// ----------------------------------------------------------------
	logic [31:0] next_dat;
	always_comb begin
		next_dat = 32'h0000_0000;
		case (adr_i)
			`TOCP_ADDR_TSC:  next_dat[7:0] = {overflow_flag, ovf_ie,
				counter_halt, 2'b00, ps_sel};
			`TOCP_ADDR_CNT:  next_dat[15:0] = count;
			`TOCP_ADDR_MOD:  next_dat[15:0] = modulo;
			`TOCP_ADDR_CSC0: next_dat[7:0] = csc[0];
			`TOCP_ADDR_CMP0: next_dat[15:0] = cmp[0];
			`TOCP_ADDR_CSC1: next_dat[7:0] = csc[1];
			`TOCP_ADDR_CMP1: next_dat[15:0] = cmp[1];
			`TOCP_ADDR_PIN:  next_dat[2:0] = {link_active_ch1, level};
			default:         next_dat = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state <= TOCP_BUS_IDLE;
			ack_o     <= 1'b0;
			dat_o     <= 32'h0000_0000;
		end else begin
			case (bus_state)
				TOCP_BUS_IDLE: begin
					if (req) begin
						ack_o     <= 1'b1;
						dat_o     <= we_i ? 32'h0000_0000 : next_dat;
						bus_state <= TOCP_BUS_ACK;
					end
				end
				TOCP_BUS_ACK: begin
					ack_o     <= 1'b0;
					bus_state <= TOCP_BUS_IDLE;
				end
				default: begin
					ack_o     <= 1'b0;
					bus_state <= TOCP_BUS_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o            <= 1'b0;
			chan0_pin_o      <= 1'b0;
			chan1_pin_o      <= 1'b0;
			chan0_pin_oe_n_o <= 1'b1;
			chan1_pin_oe_n_o <= 1'b1;
		end else begin
			irq_o <= (overflow_flag & ovf_ie)
				| (csc[0][`TOCP_CSC_FLAG] & ch_ie[0])
				| (csc[1][`TOCP_CSC_FLAG] & ch_ie[1] & ~link_on);
			chan0_pin_o      <= level[0];
			chan1_pin_o      <= level[1];
			chan0_pin_oe_n_o <= ~drive[0];
			chan1_pin_oe_n_o <= ~drive[1];
		end
	end
endmodule
`default_nettype wire
